// *** core/sig_mon_pkg.sv ***
package sig_mon_pkg;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] OFS_WIN0 = 10'h271;
   localparam logic [ADDR_W-1:0] OFS_WIN1 = 10'h272;
   localparam logic [ADDR_W-1:0] OFS_WIN2 = 10'h273;
   localparam logic [ADDR_W-1:0] OFS_LATCH_CTL = 10'h274;
   localparam logic [ADDR_W-1:0] OFS_RES0 = 10'h275;
   localparam logic [ADDR_W-1:0] OFS_RES1 = 10'h276;
   localparam logic [ADDR_W-1:0] OFS_RES2 = 10'h277;
   localparam logic [ADDR_W-1:0] OFS_FRAME_CNT = 10'h278;
   localparam logic [ADDR_W-1:0] OFS_LINK_EN = 10'h279;
   localparam logic [ADDR_W-1:0] OFS_CONTENT_SEL = 10'h27a;
   localparam logic [ADDR_W-1:0] OFS_MON_CTL = 10'h270;
   localparam logic [ADDR_W-1:0] OFS_SYNC_CTL = 10'h26f;
   localparam logic [7:0] WIN0_RST = 8'h80;
   localparam logic [7:0] WIN12_RST = 8'h00;
   localparam int UPDATE_BIT = 4;
   localparam int SEL_MSB = 2;
   localparam logic [2:0] SEL_PEAK = 3'h1;
   localparam int PEAK_EN_BIT = 1;
   localparam int PEAK_INS_BIT = 1;
   localparam logic [7:0] CONTENT_SEL_RST = 8'h02;
   localparam logic [1:0] LINK_EN_ON = 2'h3;
   localparam int SYNC_ARM_BIT = 0;
   localparam int SYNC_NEXT_BIT = 1;
   localparam int RESULT_W = 20;
   localparam int WIN_W = 24;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      logic include_peak;
      logic [RESULT_W-1:0] peak;
      logic [7:0] frame_num;
   } stats_word_s;
endpackage

// *** core/signal_level_monitor.sv ***
// What this block does
// R1: Window length is 24-bit, three byte registers, low byte resets to 0x80.
// R2: Software programs only even window lengths; odd lengths are unsupported.
// R3: Writing result-update bit latches result and count to status; bit self-clears.
// R4: Three-bit selection picks status source; code 001 (reset) selects peak.
// R5: Status result 20 bits over three bytes; top nibble of upper reads zero.
// R6: Eight-bit frame counter increments each time the window counter expires.
// R7: Each set input-selection bit includes its statistic in the link frame; the code keeps only bit 1 (peak) and drops the others.
// R8: Input-selection bit 1, default set, inserts peak data; clearing excludes it.
// R9: Link enable field: 11 enables statistics transport, anything else disables.
// R10: Armed next-edge sync takes only first reference edge, then clears arm.
`timescale 1ns/1ps
`default_nettype none
module signal_level_monitor
   import sig_mon_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   input wire logic clk_i, // 40 MHz converter output clock
   input wire logic rst_b_i, // Async reset, active low
   input wire logic [ADDR_W-1:0] reg_addr_i, // Register address
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
   input wire logic [SAMPLE_W-1:0] sample_i, // Signed converter sample
   input wire logic sample_vld_i, // Sample valid
   input wire logic system_reference_strobe_i, // Reference pin, asynchronous
   output stats_word_s stats_o, // Statistics frame word to link framer
   output logic stats_link_en_o // Statistics transport enabled
);
   reg_req_s req;
   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   logic [7:0] win0_q;
   logic [7:0] win1_q;
   logic [7:0] win2_q;
   logic [WIN_W-1:0] win_len;
   logic [2:0] sel_q;
   logic update_q;
   logic [RESULT_W-1:0] result_q;
   logic [7:0] frame_snap_q;
   logic [1:0] link_en_q;
   logic peak_ins_q;
   logic peak_en_q;
   logic sync_arm_q;
   logic sync_next_q;
   logic [WIN_W-1:0] win_cnt_q;
   logic [RESULT_W-1:0] peak_run_q;
   logic [RESULT_W-1:0] peak_last_q;
   logic [7:0] frame_cnt_q;
   logic ref_s1_q;
   logic ref_s2_q;
   logic ref_s3_q;
   logic ref_edge;
   logic resync;
   logic expire;
   logic [SAMPLE_W-1:0] mag;
   logic [RESULT_W-1:0] mag_ext;
   logic wr_win0;
   logic wr_win1;
   logic wr_win2;
   logic wr_ctl;
   logic wr_link;
   logic wr_sel;
   logic wr_mon;
   logic wr_sync;

   assign wr_win0 = req.wr && req.addr == OFS_WIN0;
   assign wr_win1 = req.wr && req.addr == OFS_WIN1;
   assign wr_win2 = req.wr && req.addr == OFS_WIN2;
   assign wr_ctl = req.wr && req.addr == OFS_LATCH_CTL;
   assign wr_link = req.wr && req.addr == OFS_LINK_EN;
   assign wr_sel = req.wr && req.addr == OFS_CONTENT_SEL;
   assign wr_mon = req.wr && req.addr == OFS_MON_CTL;
   assign wr_sync = req.wr && req.addr == OFS_SYNC_CTL;

   // Window length bytes
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         win0_q <= WIN0_RST; // [R1]
         win1_q <= WIN12_RST; // [R1]
         win2_q <= WIN12_RST; // [R1]
      end else begin
         if (wr_win0) begin
            win0_q <= req.wdata;
         end
         if (wr_win1) begin
            win1_q <= req.wdata;
         end
         if (wr_win2) begin
            win2_q <= req.wdata;
         end
      end
   end

   // Result selection and update request
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_q <= SEL_PEAK; // [R4]
         update_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            sel_q <= req.wdata[SEL_MSB:0];
         end
         // One-cycle pulse; reads back as zero afterwards
         update_q <= wr_ctl && req.wdata[UPDATE_BIT]; // [R3]
      end
   end

   // Link controls
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_en_q <= 2'h0;
         peak_ins_q <= CONTENT_SEL_RST[PEAK_INS_BIT]; // [R8]
         peak_en_q <= 1'b0;
      end else begin
         if (wr_link) begin
            link_en_q <= req.wdata[1:0];
         end
         if (wr_sel) begin
            peak_ins_q <= req.wdata[PEAK_INS_BIT]; // [R7] [R8]
         end
         if (wr_mon) begin
            peak_en_q <= req.wdata[PEAK_EN_BIT];
         end
      end
   end

   // Reference strobe synchroniser and edge detect
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
      end else begin
         ref_s1_q <= system_reference_strobe_i;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
      end
   end
   assign ref_edge = ref_s2_q && !ref_s3_q;

   // Continuous mode resyncs on every edge; next-edge mode only once
   assign resync = sync_arm_q && ref_edge; // [R10]

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_arm_q <= 1'b0;
         sync_next_q <= 1'b0;
      end else begin
         if (wr_sync) begin
            sync_next_q <= req.wdata[SYNC_NEXT_BIT];
         end
         // Armed next-edge resync in the same cycle as a sync write: the arm clear wins
         if (resync && sync_next_q) begin
            sync_arm_q <= 1'b0; // [R10]
         end else if (wr_sync) begin
            sync_arm_q <= req.wdata[SYNC_ARM_BIT];
         end
      end
   end

   // Peak magnitude of incoming sample
   always_comb begin
      mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
      mag_ext = RESULT_W'(mag);
   end

   // Window period counter; counts down from length-1
   assign expire = win_cnt_q == '0;
   assign win_len = {win2_q, win1_q, win0_q};

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         win_cnt_q <= '0;
         frame_cnt_q <= 8'h00;
      end else if (resync) begin
         win_cnt_q <= win_len - WIN_W'(1); // [R10]
         frame_cnt_q <= 8'h00;
      end else if (expire) begin
         // Even lengths assumed; odd is not guarded
         win_cnt_q <= win_len - WIN_W'(1); // [R1] [R2]
         frame_cnt_q <= frame_cnt_q + 8'h01; // [R6]
      end else begin
         win_cnt_q <= win_cnt_q - WIN_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         peak_run_q <= '0;
         peak_last_q <= '0;
      end else if (resync || !peak_en_q) begin
         peak_run_q <= '0;
      end else if (expire) begin
         peak_last_q <= (sample_vld_i && mag_ext > peak_run_q) ? mag_ext : peak_run_q;
         peak_run_q <= '0;
      end else if (sample_vld_i && mag_ext > peak_run_q) begin
         peak_run_q <= mag_ext;
      end
   end

   // Status snapshot
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_q <= '0;
         frame_snap_q <= 8'h00;
      end else if (update_q) begin
         result_q <= (sel_q == SEL_PEAK) ? peak_last_q : '0; // [R3] [R4]
         frame_snap_q <= frame_cnt_q; // [R3] [R6]
      end
   end

   // Statistics frame word, one per window
   assign stats_link_en_o = link_en_q == LINK_EN_ON; // [R9]

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stats_o <= '0;
      end else begin
         stats_o.valid <= expire && stats_link_en_o; // [R9]
         if (expire) begin
            stats_o.include_peak <= peak_ins_q; // [R7] [R8]
            stats_o.peak <= peak_ins_q ? ((sample_vld_i && mag_ext > peak_run_q) ? mag_ext : peak_run_q) : '0;
            stats_o.frame_num <= frame_cnt_q + 8'h01;
         end
      end
   end

   // Register readback; unmapped addresses read zero
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            OFS_WIN0: reg_rdata_o <= win0_q;
            OFS_WIN1: reg_rdata_o <= win1_q;
            OFS_WIN2: reg_rdata_o <= win2_q;
            OFS_LATCH_CTL: reg_rdata_o <= {3'h0, update_q, 1'b0, sel_q};
            OFS_RES0: reg_rdata_o <= result_q[7:0];
            OFS_RES1: reg_rdata_o <= result_q[15:8];
            OFS_RES2: reg_rdata_o <= {4'h0, result_q[19:16]}; // [R5]
            OFS_FRAME_CNT: reg_rdata_o <= frame_snap_q; // [R6]
            OFS_LINK_EN: reg_rdata_o <= {6'h00, link_en_q};
            OFS_CONTENT_SEL: reg_rdata_o <= {6'h00, peak_ins_q, 1'b0};
            OFS_MON_CTL: reg_rdata_o <= {6'h00, peak_en_q, 1'b0};
            OFS_SYNC_CTL: reg_rdata_o <= {6'h00, sync_next_q, sync_arm_q};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // Assertions
   sequence s_update_req;
      wr_ctl && req.wdata[UPDATE_BIT];
   endsequence
   sequence s_armed_edge;
      sync_arm_q && sync_next_q && ref_edge;
   endsequence

   // Reset values
   a_win_reset_val: assert property (@(posedge clk_i) // [R1]
      $rose(rst_b_i) |-> win0_q == WIN0_RST)
      else $error("window low byte reset value wrong");
   a_win_reset_hi: assert property (@(posedge clk_i) // [R1]
      $rose(rst_b_i) |-> win1_q == WIN12_RST && win2_q == WIN12_RST)
      else $error("window upper bytes reset value wrong");
   a_sel_reset: assert property (@(posedge clk_i) // [R4]
      $rose(rst_b_i) |-> sel_q == SEL_PEAK)
      else $error("selection reset value wrong");
   a_ins_reset: assert property (@(posedge clk_i) // [R8]
      $rose(rst_b_i) |-> peak_ins_q)
      else $error("peak insertion reset value wrong");

   // Window counting
   a_win_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
      expire && !resync |=> win_cnt_q == $past(win_len) - WIN_W'(1))
      else $error("window counter reload wrong");
   a_win_count_down: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
      !expire && !resync |=> win_cnt_q == $past(win_cnt_q) - WIN_W'(1))
      else $error("window counter did not step");
   a_frame_incr: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      expire && !resync |=> frame_cnt_q == $past(frame_cnt_q) + 8'h01)
      else $error("frame counter did not step");
   a_stats_frame: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      expire && !resync |=> stats_o.frame_num == frame_cnt_q)
      else $error("frame number in stats word wrong");

   // Status update
   a_update_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
      s_update_req |=> update_q)
      else $error("update request not taken");
   a_update_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
      s_update_req ##1 (sel_q == SEL_PEAK) |=> result_q == $past(peak_last_q))
      else $error("result not latched on update");
   a_update_selfclr: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
      update_q |=> !update_q || $past(wr_ctl))
      else $error("update bit did not self clear");
   a_snap_frame: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      update_q |=> frame_snap_q == $past(frame_cnt_q))
      else $error("frame count not latched on update");
   a_sel_other: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R4]
      update_q && sel_q != SEL_PEAK |=> result_q == '0)
      else $error("unsupported selection gave nonzero result");

   // Readback
   a_res_top_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R5]
      req.rd && req.addr == OFS_RES2 |=> reg_rdata_o[7:4] == 4'h0)
      else $error("result upper nibble not zero");
   a_res_low_rd: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R5]
      req.rd && req.addr == OFS_RES0 |=> reg_rdata_o == 8'($past(result_q)))
      else $error("result low byte readback wrong");
   a_frame_rd: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      req.rd && req.addr == OFS_FRAME_CNT |=> reg_rdata_o == $past(frame_snap_q))
      else $error("frame count readback wrong");
   // Bus is shared upstream, so idle read data must not leak state
   a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !req.rd |=> reg_rdata_o == 8'h00)
      else $error("read data not zero when idle");

   // Statistics frame
   a_peak_include: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7] [R8]
      expire && !peak_ins_q |=> stats_o.peak == '0 && !stats_o.include_peak)
      else $error("excluded peak data leaked");
   a_stats_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
      !expire |=> $stable(stats_o.peak))
      else $error("stats peak changed mid window");
   a_link_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R9]
      stats_o.valid |-> $past(link_en_q) == LINK_EN_ON)
      else $error("stats sent while disabled");
   a_link_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R9]
      link_en_q != LINK_EN_ON |=> !stats_o.valid)
      else $error("stats valid with partial enable code");

   // Reference synchronisation
   a_sync_once: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
      resync && sync_next_q |=> !sync_arm_q)
      else $error("arm bit not cleared after edge");
   a_sync_ignore: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
      s_armed_edge |=> !sync_arm_q && !resync)
      else $error("second edge acted after next edge sync");
   a_sync_cont: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
      resync && !sync_next_q && !wr_sync |=> sync_arm_q)
      else $error("continuous mode lost arm bit");
   a_resync_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
      resync |=> frame_cnt_q == 8'h00)
      else $error("frame counter not cleared on resync");
endmodule // signal_level_monitor
`default_nettype wire

// *** testbench/signal_level_monitor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module signal_level_monitor_tb_top
   import sig_mon_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [ADDR_W-1:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [15:0] sample_i = 16'h0000;
   logic sample_vld_i = 1'b0;
   logic system_reference_strobe_i = 1'b0;
   stats_word_s stats_o;
   logic stats_link_en_o;
   int errors = 0;
   int cmp_count = 0;
   int gap;
   logic [7:0] fnum;

   signal_level_monitor #(.SAMPLE_W(16)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .sample_i(sample_i), .sample_vld_i(sample_vld_i), .system_reference_strobe_i(system_reference_strobe_i),
      .stats_o(stats_o), .stats_link_en_o(stats_link_en_o));

   always #12.5 clk_i = ~clk_i;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask

   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, reg_rdata_o});
   endtask

   // Returns cycles waited; the pulse lasts one cycle, so poll each cycle
   task automatic wait_valid(output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (stats_o.valid !== 1'b1 && n < 400);
      if (n >= 400) begin
         errors++;
         $display("FAIL stats valid expected 1 seen timeout");
         conclude();
      end
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      rd(OFS_WIN0, WIN0_RST);
      rd(OFS_WIN1, WIN12_RST);
      rd(OFS_WIN2, WIN12_RST);
      rd(OFS_LATCH_CTL, 8'h01);
      rd(OFS_CONTENT_SEL, CONTENT_SEL_RST);
      rd(OFS_LINK_EN, 8'h00);
      wr(OFS_WIN0, 8'h04);
      wr(OFS_MON_CTL, 8'h02);
      sample_vld_i <= 1'b1;
      sample_i <= 16'hfed4;
      repeat (12) @(posedge clk_i);
      #1;
      chk("valid while disabled", 0, stats_o.valid);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_LINK_EN, 8'(c));
         #1;
         chk("link enable", (c == 3), stats_link_en_o);
      end
      wait_valid(gap);
      wait_valid(gap);
      fnum = stats_o.frame_num;
      wait_valid(gap);
      chk("window spacing", 4, gap);
      chk("frame number", 32'(fnum + 8'h01), stats_o.frame_num);
      chk("stats peak", 32'h12c, stats_o.peak);
      chk("include peak", 1, stats_o.include_peak);
      wr(OFS_CONTENT_SEL, 8'h00);
      wait_valid(gap);
      wait_valid(gap);
      chk("include peak off", 0, stats_o.include_peak);
      chk("peak excluded", 0, stats_o.peak);
      wr(OFS_CONTENT_SEL, CONTENT_SEL_RST);
      // Long window so the counter cannot move between pulse and snapshot
      wr(OFS_WIN0, 8'h40);
      wait_valid(gap);
      wait_valid(gap);
      fnum = stats_o.frame_num;
      wr(OFS_LATCH_CTL, 8'h11);
      // Read lands while the update pulse still stands
      rd(OFS_LATCH_CTL, 8'h11);
      rd(OFS_RES0, 8'h2c);
      rd(OFS_RES1, 8'h01);
      rd(OFS_RES2, 8'h00);
      rd(OFS_FRAME_CNT, fnum);
      rd(OFS_LATCH_CTL, 8'h01);
      wr(OFS_LATCH_CTL, 8'h12);
      repeat (2) @(posedge clk_i);
      rd(OFS_RES0, 8'h00);
      rd(OFS_LATCH_CTL, 8'h02);
      wr(OFS_LATCH_CTL, 8'h01);
      wr(OFS_RES0, 8'hff);
      rd(OFS_RES0, 8'h00);
      rd(10'h280, 8'h00);
      wr(OFS_SYNC_CTL, 8'h03);
      rd(OFS_SYNC_CTL, 8'h03);
      system_reference_strobe_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      system_reference_strobe_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(OFS_SYNC_CTL, 8'h02);
      wait_valid(gap);
      chk("frame after sync", 1, stats_o.frame_num);
      system_reference_strobe_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      system_reference_strobe_i <= 1'b0;
      wait_valid(gap);
      chk("frame after ignored edge", 2, stats_o.frame_num);
      wr(OFS_SYNC_CTL, 8'h01);
      system_reference_strobe_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      system_reference_strobe_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(OFS_SYNC_CTL, 8'h01);
      wait_valid(gap);
      chk("frame after continuous sync", 1, stats_o.frame_num);
      conclude();
   end
endmodule // signal_level_monitor_tb_top
`default_nettype wire
